/* File: dv/sbd_ctrl_model.sv */
// Controller model driving the shared link lines
`default_nettype none
module sbd_ctrl_model
(
   output logic       shiftClk,  // Link clock, still between frames
   output logic       dataIn,    // Shared serial data
   output logic [1:0] enableN    // One enable per chain or single display, active low
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // Idle levels
   // ---------------------------------------------
   initial
   begin
      shiftClk = 1'b0;
      dataIn   = 1'b0;
      enableN  = 2'h3;
   end
   // ---------------------------------------------
   // Frame sender, MSB first, 64 ns per bit
   // ---------------------------------------------
   task automatic send(input logic [95:0] bits, input int n, input logic [1:0] selN);
      #7;                    // Link phase unrelated to the system clock
      enableN = selN;        // Select first
      #16;
      for (int i = n - 1; i >= 0; i--)
      begin
         dataIn = bits[i];   // Stable across the fall
         #16 shiftClk = 1'b1;
         #32 shiftClk = 1'b0;
         #16;
      end
      enableN = 2'h3;        // Deselect after last bit
      dataIn  = ~dataIn;     // Released line shows no stale bit
   endtask
endmodule
`default_nettype wire

/* File: dv/serial_bcd_display_loader_tb.sv */
// Testbench: chained long displays and a short display on one link
`default_nettype none
module serial_bcd_display_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;   // System clock
   logic        resetn = 1'b0; // Reset, active low
   logic        shiftClk, dataIn, carry;
   logic [1:0]  enableN;      // Bit 0 chain, bit 1 short
   logic [47:0] codesA, codesB, codesS;
   logic [3:0]  pointsS;
   logic [95:0] segsA, segsS;
   logic        doneA, doneS;
   int          n_fail = 0;
   int          check_count = 0;
   int          nDoneA = 0;
   int          nDoneS = 0;
   always #4 clk = ~clk;
   // Count latch pulses at the falling edge, where they have settled
   always @(negedge clk)
   begin
      if (doneA === 1'b1) nDoneA++;
      if (doneS === 1'b1) nDoneS++;
   end
   sbd_ctrl_model ctl_u (.shiftClk(shiftClk), .dataIn(dataIn), .enableN(enableN));
   sbd_loader dut_u (.clk(clk), .resetn(resetn), .shiftClk(shiftClk), .enableN(enableN[0]),
      .dataIn(dataIn), .dataOut(carry), .shownCodes(codesA), .shownPoints(),
      .segments(segsA), .frameDone(doneA));
   sbd_loader dut_c (.clk(clk), .resetn(resetn), .shiftClk(shiftClk), .enableN(enableN[0]),
      .dataIn(carry), .dataOut(), .shownCodes(codesB), .shownPoints(),
      .segments(), .frameDone());
   sbd_loader #(.Variant(sbd_pkg::VarShort)) dut_s (.clk(clk), .resetn(resetn),
      .shiftClk(shiftClk), .enableN(enableN[1]), .dataIn(dataIn), .dataOut(),
      .shownCodes(codesS), .shownPoints(pointsS), .segments(segsS), .frameDone(doneS));
   // ---------------------------------------------
   // Compare and close
   // ---------------------------------------------
   task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_chain;
      ctl_u.send({48'habcdef543210, 48'h123456789012}, 96, 2'b10);
      repeat (12) @(negedge clk);
      check("near codes", 48'h123456789012, codesA);
      check("far codes", 48'habcdef543210, codesB);
      check("short idle", 16'hffff, codesS[15:0]);
      check("done pulses", 1, nDoneA);
      check("digit two segs", 7'h5b, segsA[6:0]);
      check("digit eight segs", 7'h7f, segsA[38:32]);
   endtask
   task automatic t_short;
      ctl_u.send({4'h9, 1'b0, 4'h0, 1'b1, 4'h4, 1'b0, 4'h7, 1'b0}, 20, 2'b01);
      repeat (12) @(negedge clk);
      check("short codes", 16'h9047, codesS[15:0]);
      check("short points", 4'h4, pointsS);
      check("short point segs", 8'hbf, segsS[23:16]);
      check("short seven segs", 8'h07, segsS[7:0]);
      check("short done", 1, nDoneS);
      check("long held", 48'h123456789012, codesA);
   endtask
   task automatic t_ignored;
      ctl_u.send(96'h0, 48, 2'b11);
      repeat (12) @(negedge clk);
      check("long unchanged", 48'h123456789012, codesA);
      check("short unchanged", 16'h9047, codesS[15:0]);
      check("no latch", 2, nDoneA + nDoneS);
   endtask
   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      check("reset codes", 48'hffffffffffff, codesA);
      check("reset points", 4'h0, pointsS);
      check("blank segs", 8'h00, segsA[7:0]);
      t_chain();
      t_short();
      t_ignored();
      test_done();
   end
   initial
   begin
      #100us;
      n_fail++;
      test_done();
   end
endmodule
`default_nettype wire

/* File: pkg/sbd_pkg.sv */
// Constants and types shared by the serial display loader
`default_nettype none
package sbd_pkg;
   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam int DigitBits  = 4;       // Bits per BCD digit code
   localparam int ShortFrame = 20;      // Four digits plus four point bits
   localparam int ShortDigits = 4;      // Digits of the short display
   localparam int LongFrame  = 48;      // Two rows of six digits
   localparam int RowBits    = 24;      // Bits of one row
   // ----------------------------------------------------------------
   // Character codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CodeNineMax = 4'h9;  // Highest decimal code
   localparam logic [3:0] CodeBlank   = 4'hf;  // Blank position
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [47:0] ShownReset = 48'hffffffffffff;  // All blank
   // Display variant selection
   typedef enum logic [1:0]
   {
      VarShort = 2'b01,
      VarLong  = 2'b10
   } sbd_variant_type;
endpackage
`default_nettype wire

/* File: verilog/sbd_loader.sv */
// Serial BCD display loader: link shifter, frame latch, segment drive
//
// Behaviour
// - Enable low accepts bits; high holds display.
// - Data bits sampled on falling shift clock.
// - Codes decode to digits, blank, symbols.
// - Long frame: upper row, lower row, MSB first.
// - Carry data output feeds chained modules.
`default_nettype none
module sbd_loader
#(
   parameter sbd_pkg::sbd_variant_type Variant = sbd_pkg::VarLong  // Display type
)
(
   input  wire logic        clk,          // System clock, 125 MHz
   input  wire logic        resetn,       // Synchronous reset, active low
   input  wire logic        shiftClk,     // Link shift clock from controller
   input  wire logic        enableN,      // Link enable, active low
   input  wire logic        dataIn,       // Link serial data
   output logic             dataOut,      // Carry data to next module
   output logic      [47:0] shownCodes,   // Latched codes, upper row high
   output logic      [3:0]  shownPoints,  // Latched points, short variant
   output logic      [95:0] segments,     // Segment drive, eight per position
   output logic             frameDone     // Pulse when a frame is latched
);
   // ----------------------------------------------------------------
   // Link domain state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [47:0] shift;    // Serial shift chain, last stage drives the carry
   } sbd_link_type;

   sbd_link_type linkQ;     // Registered link state
   sbd_link_type linkD;     // Next link state

   // Shift chain width per variant
   localparam int ChainBits = (Variant == sbd_pkg::VarShort) ?
                              sbd_pkg::ShortFrame : sbd_pkg::LongFrame;

   // Next link state; data shifted in MSB first
   always_comb
   begin
      linkD = linkQ;
      if (!enableN)
      begin
         linkD.shift = {linkQ.shift[46:0], dataIn};
      end
   end

   // Falling shift clock samples data; no reset, controller always frames
   always_ff @(negedge shiftClk)
   begin
      linkQ <= linkD;
   end

   // Carry path: the last stage itself feeds the next module, so a chain of n
   // modules takes exactly n times ChainBits bits in one frame; an extra flop here would cost one bit
   assign dataOut = linkQ.shift[ChainBits-1];

   // ----------------------------------------------------------------
   // System domain state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0]  enSync;   // Enable synchroniser
      logic        enOld;    // Previous synchronised enable
      logic        quiet;    // Enable still high, chain settled
      logic [47:0] shown;    // Latched shown codes
      logic [3:0]  points;   // Latched decimal points
      logic        done;     // Latch pulse
   } sbd_sys_type;

   sbd_sys_type sysQ;       // Registered system state
   sbd_sys_type sysD;       // Next system state
   logic        enRise;     // Enable returned high

   // Next system state; shift chain is stable while enable is high
   always_comb
   begin
      sysD         = sysQ;
      sysD.enSync  = {sysQ.enSync[0], enableN};
      sysD.enOld   = sysQ.enSync[1];
      sysD.done    = 1'b0;
      enRise       = sysQ.enSync[1] & ~sysQ.enOld;
      if (enRise)
      begin
         sysD.done = 1'b1;
         if (Variant == sbd_pkg::VarShort)
         begin
            // Each digit: four code bits then its point bit
            for (int i = 0; i < sbd_pkg::ShortDigits; i++)
            begin
               sysD.shown[i*4 +: 4] = linkQ.shift[i*5+1 +: 4];
               sysD.points[i]       = linkQ.shift[i*5];
            end
         end
         else
         begin
            sysD.shown = linkQ.shift;
         end
      end
      // The chain only moves while enable is low, so it is settled as long
      // as the synchronised enable stays high
      sysD.quiet = sysQ.enSync[1];
   end

   // System registers with synchronous reset
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sysQ.enSync  <= 2'b11;
         sysQ.enOld   <= 1'b1;
         sysQ.quiet   <= 1'b1;
         sysQ.shown   <= sbd_pkg::ShownReset;
         sysQ.points  <= 4'h0;
         sysQ.done    <= 1'b0;
      end
      else
      begin
         sysQ <= sysD;
      end
   end

   assign shownCodes  = sysQ.shown;
   assign shownPoints = sysQ.points;
   assign frameDone   = sysQ.done;

   // ----------------------------------------------------------------
   // Segment decoders, one per digit position
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 12; g++)
   begin : gDigit
      logic pt;  // Point for this position
      assign pt = (Variant == sbd_pkg::VarShort && g < 4) ? sysQ.points[g] : 1'b0;
      sbd_seg_decode uDec
      (
         .code  (sysQ.shown[g*4 +: 4]),
         .point (pt),
         .segs  (segments[g*8 +: 8])
      );
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Shown content only changes on a latch
   a_hold_shown: assert property (@(posedge clk) disable iff (!resetn)
      !sysQ.done |=> $stable(shownCodes) || frameDone)
      else $error("Shown codes changed without a latch");

   // Latch follows the synchronised rising enable by one cycle
   a_latch_time: assert property (@(posedge clk) disable iff (!resetn)
      (sysQ.enSync[1] && !sysQ.enOld) |=> frameDone)
      else $error("Frame not latched after enable rose");

   // Latch pulse lasts a single cycle
   a_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
      frameDone |=> !frameDone)
      else $error("Latch pulse longer than one cycle");

   // Long variant latches the whole chain, upper row first
   a_long_copy: assert property (@(posedge clk) disable iff (!resetn)
      (Variant == sbd_pkg::VarLong && frameDone && sysQ.quiet)
      |-> shownCodes == linkQ.shift)
      else $error("Long frame latch mismatch");

   // No sampled bits while enable is high
   a_idle_link: assert property (@(negedge shiftClk)
      enableN |=> $stable(linkQ.shift))
      else $error("Shift chain moved while disabled");

   // Each enabled falling edge shifts data into bit zero; the chain has no
   // reset, so unfilled stages compare as they stand
   a_shift_in: assert property (@(negedge shiftClk)
      !enableN |=> linkQ.shift[0] === $past(dataIn))
      else $error("Data bit not shifted in");

   // Carry output takes the next-to-last stage on each enabled edge
   a_carry_out: assert property (@(negedge shiftClk)
      !enableN |=> dataOut === $past(linkQ.shift[ChainBits-2]))
      else $error("Carry output wrong");

   // Short variant point 0 comes from bit zero of the frame
   a_short_pts: assert property (@(posedge clk) disable iff (!resetn)
      (Variant == sbd_pkg::VarShort && frameDone && sysQ.quiet)
      |-> shownPoints[0] == linkQ.shift[0])
      else $error("Short frame point misplaced");

   // Short variant first digit code sits on top of the frame
   a_short_codes: assert property (@(posedge clk) disable iff (!resetn)
      (Variant == sbd_pkg::VarShort && frameDone && sysQ.quiet)
      |-> shownCodes[15:12] == linkQ.shift[19:16])
      else $error("Short frame digit misplaced");

   // Blank code drives no segments
   a_blank_dark: assert property (@(posedge clk) disable iff (!resetn)
      shownCodes[3:0] == sbd_pkg::CodeBlank |-> segments[6:0] == 7'h00)
      else $error("Blank position lit");

   // Decimal codes always light some segment
   a_digit_lit: assert property (@(posedge clk) disable iff (!resetn)
      shownCodes[3:0] <= sbd_pkg::CodeNineMax |-> segments[6:0] != 7'h00)
      else $error("Decimal digit dark");

   // No latch while the synchronised enable is still low
   a_no_early: assert property (@(posedge clk) disable iff (!resetn)
      !sysQ.enSync[1] |=> !frameDone)
      else $error("Frame latched while enable low");

   // A latch is only reported once the enable has settled high
   a_latch_settled: assert property (@(posedge clk) disable iff (!resetn)
      frameDone |-> sysQ.enOld)
      else $error("Latch before enable settled");
endmodule
`default_nettype wire

/* File: verilog/sbd_seg_decode.sv */
// Seven-segment decoder for one digit position
`default_nettype none
module sbd_seg_decode
(
   input  wire logic [3:0] code,      // BCD or symbol code
   input  wire logic       point,     // Decimal point request
   output logic      [7:0] segs       // Segments g..a plus point in bit 7
);
   // Decode table, segment a is bit 0
   always_comb
   begin
      unique case (code)
         4'h0: segs[6:0] = 7'h3f;
         4'h1: segs[6:0] = 7'h06;
         4'h2: segs[6:0] = 7'h5b;
         4'h3: segs[6:0] = 7'h4f;
         4'h4: segs[6:0] = 7'h66;
         4'h5: segs[6:0] = 7'h6d;
         4'h6: segs[6:0] = 7'h7d;
         4'h7: segs[6:0] = 7'h07;
         4'h8: segs[6:0] = 7'h7f;
         4'h9: segs[6:0] = 7'h6f;
         4'ha: segs[6:0] = 7'h08;  // Low bar symbol
         4'hb: segs[6:0] = 7'h30;  // Left bars symbol
         4'hc: segs[6:0] = 7'h06;  // Right bars symbol
         4'hd: segs[6:0] = 7'h49;  // Three bars symbol
         4'he: segs[6:0] = 7'h40;  // Dash
         4'hf: segs[6:0] = 7'h00;  // Blank
      endcase
      segs[7] = point;
   end
endmodule
`default_nettype wire
